//--- hw/ttyb_pkg.sv
// Constants and carriers for the teletype burst readout block.
// Assumes a 200 MHz pclk and an APB master with 32-bit data.
package ttyb_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS     = 5;
	localparam int CLK_HZ            = 1000000000 / CLK_PERIOD_NS;
	localparam int STEP_RATE_PPS     = 91;
	localparam int SLOW_STEP_CYCLES  = CLK_HZ / STEP_RATE_PPS;
	localparam int PHASE_TIME_NS     = 10000;
	localparam int PHASE_CYCLES      = PHASE_TIME_NS / CLK_PERIOD_NS;
	localparam int FAST_STEP_NS      = 20000;
	localparam int FAST_STEP_PHASES  = FAST_STEP_NS / PHASE_TIME_NS;

	// Geometry
	localparam int CHANNELS          = 25;
	localparam int ARRAY_ROWS        = 26;
	localparam int COLUMNS           = 22;

	// Step counter landmarks
	localparam logic [5:0] CNT_PRIMED     = 6'h00;
	localparam logic [5:0] CNT_FAST_START = 6'h02;
	localparam logic [5:0] CNT_FAST_END   = 6'h08;
	localparam logic [5:0] CNT_SEARCH_SET = 6'h2D;
	localparam logic [5:0] CNT_LAST       = 6'h33;
	localparam logic [5:0] CNT_FIRST      = 6'h01;

	// Columns 4 to 6 carry no data
	localparam logic [21:0] USED_COL_MASK = 22'h3FFFC7;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_STATUS     = 8'h04;
	localparam logic [7:0] REG_WDATA      = 8'h08;
	localparam logic [7:0] REG_LINE       = 8'h0C;
	localparam logic [7:0] REG_WMASK      = 8'h10;
	localparam logic [7:0] REG_ALARM_CHAN = 8'h14;

	// Control fields and reset values
	localparam int CTRL_RUN_BIT         = 0;
	localparam int CTRL_CLR_ALARM_BIT   = 8;
	localparam int CTRL_CLR_REFUSED_BIT = 9;
	localparam logic CTRL_RUN_RESET     = 1'b1;
	localparam logic PARITY_ODD         = 1'b1;

	// 32-bit word write carrier, as written to REG_WDATA
	typedef struct packed {
		logic [2:0]  unused;
		logic [4:0]  row;
		logic [1:0]  pad;
		logic [21:0] cols;
	} ttyb_word_t;

	// Status word, as read from REG_STATUS
	typedef struct packed {
		logic [13:0] zero_hi;
		logic        refused;
		logic        alarm;
		logic [4:0]  zero_mid;
		logic        run;
		logic        fast;
		logic        search;
		logic [1:0]  zero_lo;
		logic [5:0]  count;
	} ttyb_status_t;

endpackage

//--- hw/ttyb_readout.sv
// Teletype burst readout: core array, 51-step sequencer, shifters, line register.
// Assumes an APB master on pclk; relays and read-in control sit outside.
`timescale 1ns/1ps

module ttyb_readout
	import ttyb_pkg::*;
#(
	parameter int SLOW_STEP_CYCLES = ttyb_pkg::SLOW_STEP_CYCLES,
	parameter int PHASE_CYCLES     = ttyb_pkg::PHASE_CYCLES
)(
	// Clock and reset
	input  logic                           pclk,
	input  logic                           presetn,
	// APB slave
	input  logic                           psel,
	input  logic                           penable,
	input  logic                           pwrite,
	input  logic [7:0]                     paddr,
	input  logic [31:0]                    pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Teletype lines, 1 = open (space)
	output logic [ttyb_pkg::CHANNELS-1:0]  line_relay_open,
	// Read-in and alarm control
	output logic                           accept_window_level,
	output logic                           shift_time_pulse,
	output logic                           alarm_pulse
);

	////////////////////////////////////////////////////////////////////////////
	// Step table

	// Column dumped by each count, zero where none
	function automatic logic [4:0] dump_column(input logic [5:0] c);
		case (c)
			6'h01: dump_column = 5'h16;
			6'h03: dump_column = 5'h01;
			6'h05: dump_column = 5'h07;
			6'h07: dump_column = 5'h08;
			6'h09: dump_column = 5'h09;
			6'h0B: dump_column = 5'h0A;
			6'h0D: dump_column = 5'h0B;
			6'h11: dump_column = 5'h02;
			6'h13: dump_column = 5'h0C;
			6'h15: dump_column = 5'h0D;
			6'h18: dump_column = 5'h0E;
			6'h1A: dump_column = 5'h0F;
			6'h1C: dump_column = 5'h10;
			6'h20: dump_column = 5'h03;
			6'h22: dump_column = 5'h11;
			6'h24: dump_column = 5'h12;
			6'h27: dump_column = 5'h13;
			6'h29: dump_column = 5'h14;
			6'h2B: dump_column = 5'h15;
			default: dump_column = 5'h00;
		endcase
	endfunction

	// Counts that raise the shift-time pulse
	function automatic logic is_shift_time(input logic [5:0] c);
		case (c)
			6'h02, 6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10,
			6'h12, 6'h14, 6'h17, 6'h19, 6'h1B, 6'h1D, 6'h1F, 6'h21,
			6'h23, 6'h26, 6'h28, 6'h2A, 6'h2C, 6'h2E, 6'h30, 6'h32:
				is_shift_time = 1'b1;
			default:
				is_shift_time = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	logic [11:0]           phase_cnt;
	logic [21:0]           slow_cnt;
	logic                  slow_pend;
	logic [1:0]            fast_phase;
	logic                  fast;
	logic                  stretch;
	logic [5:0]            count;
	logic                  search;
	logic                  run;
	logic [CHANNELS-1:0]   stage1;
	logic [CHANNELS-1:0]   stage2;
	logic [CHANNELS-1:0]   stage3;
	logic [CHANNELS-1:0]   line_reg;
	logic [CHANNELS-1:0]   par_acc;
	logic [CHANNELS-1:0]   row_loaded;
	logic [CHANNELS-1:0]   row_checked;
	logic [CHANNELS-1:0]   alarm_chan;
	logic                  alarm;
	logic                  refused;
	logic [21:0]           wmask;
	logic [COLUMNS-1:0]    core_array [0:ARRAY_ROWS-1];

	////////////////////////////////////////////////////////////////////////////
	// Timing enables

	wire phase_three = (phase_cnt == 12'(PHASE_CYCLES - 1));
	wire slow_tick   = (slow_cnt == 22'(SLOW_STEP_CYCLES - 1));
	wire fast_due    = (fast_phase == 2'(FAST_STEP_PHASES - 1));
	// Stretch eats one phase cycle after count 51
	wire step_now    = phase_three && run && !stretch
	                 && (fast ? fast_due : slow_pend);
	wire [5:0] next_count = count + 6'h01;
	wire [4:0] col_sel    = step_now ? dump_column(next_count) : 5'h00;
	wire       dump_now   = (col_sel != 5'h00);
	// Shift at 8 lands the start bit; skipping it loses a bit at 9
	wire       shift_now  = step_now && is_shift_time(next_count);
	wire       fast_range = (next_count > CNT_FAST_START)
	                      && (next_count < CNT_FAST_END);
	wire [21:0] clr_mask  = dump_now ? (22'h000001 << (col_sel - 5'h01)) : 22'h000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_cnt <= 12'h000;
			slow_cnt  <= 22'h000000;
		end else begin
			phase_cnt <= phase_three ? 12'h000 : phase_cnt + 12'h001;
			slow_cnt  <= slow_tick ? 22'h000000 : slow_cnt + 22'h000001;
		end
	end

	// Slow ticks wait for the next phase-three enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_pend <= 1'b0;
		end else if (slow_tick) begin
			slow_pend <= 1'b1;
		end else if (step_now) begin
			slow_pend <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// 51-step counter and flags

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count      <= CNT_PRIMED;
			stretch    <= 1'b0;
			fast       <= 1'b0;
			fast_phase <= 2'h0;
			search     <= 1'b0;
		end else begin
			if (stretch && phase_three) begin
				count   <= CNT_PRIMED;
				stretch <= 1'b0;
			end else if (step_now) begin
				count <= next_count;
				if (next_count == CNT_LAST) begin
					stretch <= 1'b1;
				end
			end
			if (step_now && next_count == CNT_FAST_START) begin
				fast <= 1'b1;
			end else if (step_now && next_count == CNT_FAST_END) begin
				fast <= 1'b0;
			end
			if (!fast || step_now) begin
				fast_phase <= 2'h0;
			end else if (phase_three) begin
				fast_phase <= fast_phase + 2'h1;
			end
			if (step_now && next_count == CNT_SEARCH_SET) begin
				search <= 1'b1;
			end else if (step_now && next_count == CNT_LAST) begin
				search <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Column sense and shifters

	logic [CHANNELS-1:0] column_sense_amp;

	always_comb begin
		column_sense_amp = '0;
		for (int r = 0; r < CHANNELS; r++) begin
			column_sense_amp[r] = dump_now ? core_array[r][col_sel - 5'h01] : 1'b0;
		end
	end

	// Dump and shift never share a count, so one branch at a time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1   <= '0;
			stage2   <= '0;
			stage3   <= '0;
			line_reg <= '0;
		end else if (dump_now) begin
			stage1 <= column_sense_amp;
		end else if (shift_now) begin
			stage1   <= '0;
			stage2   <= stage1;
			stage3   <= stage2;
			line_reg <= stage3;
		end
	end

	// Relays skip the fast shifts at 4 and 6, so parity never shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_relay_open <= '0;
		end else if (shift_now && !fast_range) begin
			line_relay_open <= stage3;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_time_pulse <= 1'b0;
		end else begin
			shift_time_pulse <= shift_now;
		end
	end

	assign accept_window_level = search;

	////////////////////////////////////////////////////////////////////////////
	// Parity check of outgoing bits

	wire cycle_start = step_now && (next_count == CNT_FIRST);
	wire cycle_end   = step_now && (next_count == CNT_LAST);
	wire [CHANNELS-1:0] bad_chan = row_checked & (par_acc ^ {CHANNELS{PARITY_ODD}});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			par_acc     <= '0;
			row_checked <= '0;
		end else if (cycle_start) begin
			par_acc     <= '0;
			row_checked <= row_loaded;
		end else if (shift_now) begin
			par_acc <= par_acc ^ stage3;
		end
	end

	wire apb_setup   = psel && !penable;
	wire apb_wr      = psel && penable && pwrite;
	wire clr_alarm   = apb_wr && (paddr == REG_CTRL) && pwdata[CTRL_CLR_ALARM_BIT];
	wire clr_refused = apb_wr && (paddr == REG_CTRL) && pwdata[CTRL_CLR_REFUSED_BIT];
	wire raise_alarm = cycle_end && (bad_chan != '0);

	// A new failure beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm       <= 1'b0;
			alarm_chan  <= '0;
			alarm_pulse <= 1'b0;
		end else begin
			alarm_pulse <= raise_alarm;
			if (raise_alarm) begin
				alarm      <= 1'b1;
				alarm_chan <= alarm_chan | bad_chan;
			end else if (clr_alarm) begin
				alarm      <= 1'b0;
				alarm_chan <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB decode

	wire mapped    = (paddr == REG_CTRL) || (paddr == REG_STATUS)
	              || (paddr == REG_WDATA) || (paddr == REG_LINE)
	              || (paddr == REG_WMASK) || (paddr == REG_ALARM_CHAN);

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	ttyb_word_t word_in;
	assign word_in = ttyb_word_t'(pwdata);

	wire wr_fire = apb_wr && (paddr == REG_WDATA);
	wire wr_hit  = wr_fire && search && (word_in.row < 5'(ARRAY_ROWS));
	wire [21:0] write_sel = wmask & USED_COL_MASK;

	ttyb_status_t status;
	always_comb begin
		status          = '0;
		status.count    = count;
		status.search   = search;
		status.fast     = fast;
		status.run      = run;
		status.alarm    = alarm;
		status.refused  = refused;
	end

	logic [31:0] rd_mux;
	always_comb begin
		case (paddr)
			REG_CTRL:       rd_mux = {31'h00000000, run};
			REG_STATUS:     rd_mux = status;
			REG_LINE:       rd_mux = {7'h00, line_reg};
			REG_WMASK:      rd_mux = {10'h000, wmask};
			REG_ALARM_CHAN: rd_mux = {7'h00, alarm_chan};
			default:        rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (apb_setup && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run     <= CTRL_RUN_RESET;
			wmask   <= USED_COL_MASK;
			refused <= 1'b0;
		end else begin
			if (apb_wr && paddr == REG_CTRL) begin
				run <= pwdata[CTRL_RUN_BIT];
			end
			if (apb_wr && paddr == REG_WMASK) begin
				wmask <= pwdata[21:0] & USED_COL_MASK;
			end
			if (wr_fire && !wr_hit) begin
				refused <= 1'b1;
			end else if (clr_refused) begin
				refused <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Core array

	// Dump clears its column; a write loads only the masked columns of its row
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int r = 0; r < ARRAY_ROWS; r++) begin
				core_array[r] <= '0;
			end
		end else begin
			for (int r = 0; r < ARRAY_ROWS; r++) begin
				if (wr_hit && word_in.row == 5'(r)) begin
					core_array[r] <= (core_array[r] & ~clr_mask & ~write_sel)
					               | (word_in.cols & write_sel);
				end else begin
					core_array[r] <= core_array[r] & ~clr_mask;
				end
			end
		end
	end

	// Rows 0 to 24 written this search are checked next readout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			row_loaded <= '0;
		end else if (wr_hit && word_in.row < 5'(CHANNELS)) begin
			row_loaded <= row_loaded | (25'h0000001 << word_in.row);
		end else if (cycle_start) begin
			row_loaded <= '0;
		end
	end

endmodule

//--- sim/ttyb_readout_properties.sv
// Port timing checker for the teletype burst readout block.
// Assumes it is bound onto ttyb_readout; one clock domain.
`timescale 1ns/1ps
module ttyb_readout_properties #(
	parameter int SLOW_STEP_CYCLES = 4000,
	parameter int PHASE_CYCLES     = 2000
)(
	// Clock and reset
	input wire logic                          pclk,
	input wire logic                          presetn,
	// Observed outputs
	input wire logic [ttyb_pkg::CHANNELS-1:0] line_relay_open,
	input wire logic                          accept_window_level,
	input wire logic                          shift_time_pulse,
	input wire logic                          alarm_pulse
);
	import ttyb_pkg::*;

	// Cycles since last shift, cycles inside window
	int unsigned gap;
	int unsigned win;
	logic        last_srch;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap <= 0;
			win <= 0;
			last_srch <= 1'b0;
		end else begin
			gap <= shift_time_pulse ? 0 : gap + 1;
			win <= accept_window_level ? win + 1 : 0;
			if (shift_time_pulse)
				last_srch <= accept_window_level;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////
	property p_relay_at_shift;
		$changed(line_relay_open) |-> shift_time_pulse || $past(shift_time_pulse);
	endproperty
	a_relay_at_shift: assert property (p_relay_at_shift)
		else $error("relay moved without shift");
	property p_shift_one;
		shift_time_pulse |=> !shift_time_pulse;
	endproperty
	a_shift_one: assert property (p_shift_one)
		else $error("shift pulse too long");
	property p_shift_gap;
		shift_time_pulse |-> gap >= 3 * PHASE_CYCLES;
	endproperty
	a_shift_gap: assert property (p_shift_gap)
		else $error("shifts too close");
	property p_search_len;
		$fell(accept_window_level) |-> win >= 5 * SLOW_STEP_CYCLES
			&& win <= 7 * SLOW_STEP_CYCLES;
	endproperty
	a_search_len: assert property (p_search_len)
		else $error("search window length wrong");
	property p_search_feed;
		accept_window_level |-> gap < 3 * SLOW_STEP_CYCLES;
	endproperty
	a_search_feed: assert property (p_search_feed)
		else $error("line starved in search");
	property p_stop_hold;
		shift_time_pulse && !accept_window_level && last_srch
			|-> gap >= 2 * SLOW_STEP_CYCLES;
	endproperty
	a_stop_hold: assert property (p_stop_hold)
		else $error("final stop bit cut short");
	property p_alarm_end;
		alarm_pulse |-> !accept_window_level
			&& ($past(accept_window_level) || $past(accept_window_level, 2));
	endproperty
	a_alarm_end: assert property (p_alarm_end)
		else $error("alarm off the window end");
	property p_alarm_one;
		alarm_pulse |=> !alarm_pulse;
	endproperty
	a_alarm_one: assert property (p_alarm_one)
		else $error("alarm pulse too long");
endmodule

bind ttyb_readout ttyb_readout_properties #(
	.SLOW_STEP_CYCLES (SLOW_STEP_CYCLES),
	.PHASE_CYCLES     (PHASE_CYCLES)
) u_props (
	.pclk                (pclk),
	.presetn             (presetn),
	.line_relay_open     (line_relay_open),
	.accept_window_level (accept_window_level),
	.shift_time_pulse    (shift_time_pulse),
	.alarm_pulse         (alarm_pulse)
);

//--- sim/ttyb_relay_line.sv
// Far-side line relays: counts spaces seen on four channels.
// Assumes the relays are settled when the shift pulse is up.
`timescale 1ns/1ps
module ttyb_relay_line (
	// Clock and count clear
	input  wire logic                          pclk,
	input  wire logic                          clr,
	// Line side
	input  wire logic [ttyb_pkg::CHANNELS-1:0] line_relay_open,
	input  wire logic                          shift_time_pulse,
	// Space counts, one byte per channel
	output logic      [31:0]                   spaces
);
	import ttyb_pkg::*;

	always_ff @(posedge pclk) begin
		for (int c = 0; c < 4; c++) begin
			if (clr)
				spaces[c*8 +: 8] <= 8'h00;
			else if (shift_time_pulse && line_relay_open[c])
				spaces[c*8 +: 8] <= spaces[c*8 +: 8] + 8'h01;
		end
	end
endmodule

//--- sim/testbench.sv
// Self-checking bench for the teletype burst readout block.
// Assumes the relay model and the bound port checker.
`timescale 1ns/1ps
module testbench;
	import ttyb_pkg::*;

	// Short phase and step keep two bursts near 15k cycles
	localparam int PHASE = 20;
	localparam int SLOW  = 160;
	logic                pclk;
	logic                presetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [7:0]          paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic [CHANNELS-1:0] line_relay_open;
	logic                accept_window_level;
	logic                shift_time_pulse;
	logic                alarm_pulse;
	logic                clr;
	logic [31:0]         spaces;
	int                  n_fail;
	int                  samples_checked;
	int                  cyc = 0;

	ttyb_readout #(.SLOW_STEP_CYCLES(SLOW), .PHASE_CYCLES(PHASE)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .line_relay_open(line_relay_open),
		.accept_window_level(accept_window_level),
		.shift_time_pulse(shift_time_pulse), .alarm_pulse(alarm_pulse)
	);
	ttyb_relay_line u_line (
		.pclk(pclk), .clr(clr), .line_relay_open(line_relay_open),
		.shift_time_pulse(shift_time_pulse), .spaces(spaces)
	);

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			n_fail++;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x,
			input logic [31:0] m = 32'hFFFFFFFF, input logic ex = 1'b0);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h00000000, q, e);
		chk(q & m, x);
		chk({31'h00000000, e}, {31'h00000000, ex});
	endtask

	task automatic wait_win(input logic v);
		int n;
		n = 0;
		while (accept_window_level !== v && n < 20000) begin
			@(posedge pclk);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(REG_STATUS, 32'h00000400);
		rd(REG_WMASK, 32'h003FFFC7);
		rd(REG_LINE, 32'h00000000);
		rd(8'h40, 32'h00000000, 32'hFFFFFFFF, 1'b1);
		chk({7'h00, line_relay_open}, 32'h00000000);
	endtask

	task automatic t_refused();
		wr(REG_WDATA, 32'h00000001);
		rd(REG_STATUS, 32'h00020000, 32'h00020000);
		wr(REG_CTRL, 32'h00000201);
		rd(REG_STATUS, 32'h00000000, 32'h00020000);
	endtask

	task automatic t_search_write();
		wait_win(1'b1);
		rd(REG_STATUS, 32'h0000052D, 32'h0001073F);
		wr(REG_WMASK, 32'h003FFFFF);
		rd(REG_WMASK, 32'h003FFFC7);
		wr(REG_WDATA, 32'h003FFFC7);
		wr(REG_WDATA, 32'h013FFFC7);
		wr(REG_WDATA, 32'h02000003);
		// Parity column kept from the earlier write
		wr(REG_WMASK, 32'h001FFFC7);
		wr(REG_WDATA, 32'h01000047);
		wr(REG_WDATA, 32'h1A000000);
		rd(REG_STATUS, 32'h00020000, 32'h00020000);
		wr(REG_CTRL, 32'h00000201);
	endtask

	task automatic t_readout();
		wait_win(1'b0);
		@(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		rd(REG_ALARM_CHAN, 32'h00000000);
		wait_win(1'b1);
		wait_win(1'b0);
		repeat (4) @(posedge pclk);
		// 18, 4, 2, 0 spaces: no parity, zero stops
		chk(spaces, 32'h00020412);
		rd(REG_ALARM_CHAN, 32'h00000004);
		rd(REG_STATUS, 32'h00010000, 32'h00010000);
		wr(REG_CTRL, 32'h00000101);
		rd(REG_ALARM_CHAN, 32'h00000000);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		clr = 1'b1;
		n_fail = 0;
		samples_checked = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		clr <= 1'b0;
		t_reset();
		t_refused();
		t_search_write();
		t_readout();
		end_sim();
	end
endmodule
